//--- logic/region_protect_regs.vh
`ifndef REGION_PROTECT_REGS_VH
`define REGION_PROTECT_REGS_VH

// Register byte offsets
`define OFF_REGION_NUMBER        8'h00
`define OFF_BASE_PRIMARY         8'h04
`define OFF_ATTR_PRIMARY         8'h08
`define OFF_BASE_ALIAS_ONE       8'h0c
`define OFF_ATTR_ALIAS_ONE       8'h10
`define OFF_BASE_ALIAS_TWO       8'h14
`define OFF_ATTR_ALIAS_TWO       8'h18
`define OFF_BASE_ALIAS_THREE     8'h1c
`define OFF_ATTR_ALIAS_THREE     8'h20
`define OFF_REGION_CHECK         8'h24
`define OFF_REGION_STATUS        8'h28

// Base register fields
`define BASE_REGION_MSB          3
`define BASE_VALID_BIT           4
`define BASE_ADDR_MIN_BIT        5
`define BASE_STORE_MASK          32'hffffffe0

// Attribute/size register fields
`define ATTR_ENABLE_BIT          0
`define ATTR_SIZE_LSB            1
`define ATTR_SIZE_MSB            5
`define ATTR_SRD_LSB             8
`define ATTR_SRD_MSB             15
`define ATTR_B_BIT               16
`define ATTR_C_BIT               17
`define ATTR_S_BIT               18
`define ATTR_TEX_LSB             19
`define ATTR_TEX_MSB             21
`define ATTR_AP_LSB              24
`define ATTR_AP_MSB              26
`define ATTR_XN_BIT              28
`define ATTR_WRITE_MASK          32'h173fff3f

// Size encodings
`define SIZE_FULL_MAP            5'h1f
`define SIZE_MIN_LEGAL           5'h04
`define SIZE_NO_SUBREGION        5'h06

// Bus responses
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

//--- logic/region_match.v
`timescale 1ns/10ps
`include "region_protect_regs.vh"

// Decodes one region's size and checks an address against it
module region_match (
   // Region descriptor
   input wire [31:0] base,
   input wire [31:0] attr,
   // Query
   input wire [31:0] addr,
   input wire fetch,
   // Result
   output reg hit,
   output reg allow_fetch,
   output reg [31:0] base_mask,
   output reg [5:0] size_log2
);
   reg [4:0] size;
   reg [7:0] subregion_disable;
   reg [2:0] sub_idx;
   reg [31:0] low_mask;
   reg [31:0] sub_shift;

   // Size is 2^(SIZE+1); full map forces base zero
   always @* begin
      size = attr[`ATTR_SIZE_MSB:`ATTR_SIZE_LSB];
      subregion_disable = attr[`ATTR_SRD_MSB:`ATTR_SRD_LSB];
      size_log2 = {1'b0, size} + 6'h01; // [R1]
      low_mask = (size == `SIZE_FULL_MAP) ? 32'hffffffff : ((32'h00000002 << size) - 32'h00000001);
      base_mask = ~low_mask; // [R4] [R3]
      // Subregion is the top three offset bits inside the region
      sub_idx = 3'h0;
      sub_shift = 32'h00000000;
      if (size >= `SIZE_NO_SUBREGION) begin
         // Eight equal subregions, so each spans 2^(SIZE-2) bytes
         sub_shift = addr >> (size - 5'h02);
         sub_idx = sub_shift[2:0];
      end
      hit = attr[`ATTR_ENABLE_BIT] && ((addr & base_mask) == (base & base_mask)); // [R17] [R6] [R3]
      if (size > `SIZE_NO_SUBREGION && subregion_disable[sub_idx])
         hit = 1'b0; // [R15]
      allow_fetch = !(hit && fetch && attr[`ATTR_XN_BIT]); // [R14]
   end
endmodule // region_match

//--- logic/region_protect_alias_regs.v
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "region_protect_regs.vh"

// Summary of operation
// [R1] Region size in bytes equals two to the power of size field plus one.
// [R2] Software never programs a size field below four, thirty-two bytes.
// [R3] A full-map size covers everything from base zero; base field ignored.
// [R4] Base field spans bit 31 down to log2 of the region size.
// [R5] Software writes a base that is a multiple of the region size.
// [R6] Region start always lies on a boundary equal to its size.
// [R7] Base write with select-valid clear updates current region, index ignored.
// [R8] Base write with select-valid set loads region number then updates that base.
// [R9] Select-valid bit always reads zero.
// [R10] Region index field reads back the current region number.
// [R11] Every base alias describes the region chosen by the region number.
// [R12] Every attribute alias holds size, attributes, enables for chosen region.
// [R13] Attribute register takes word and half-word writes via strobes.
// [R14] Execute-never set blocks instruction fetches from the region.
// [R15] A set subregion-disable bit disables that subregion.
// [R16] Software writes zero subregion-disable for regions of 128 bytes or less.
// [R17] Region enable bit puts the region and enabled subregions in effect.
// [R18] Base: index 3..0, valid bit 4; attribute field layout as defined.
// [R19] All alias pairs act exactly like the primary pair on shared storage.
module region_protect_alias_regs #(
   parameter REGIONS = 8,
   parameter IDX_W = 3
) (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // Region storage shared by every alias pair
   reg [31:0] base_mem [0:REGIONS-1];
   reg [31:0] attr_mem [0:REGIONS-1];
   reg [IDX_W-1:0] region_number_reg;
   reg [31:0] check_addr_reg;
   reg check_fetch_reg;
   reg [7:0] awaddr_reg;
   reg aw_held_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg w_held_reg;
   integer i;

   wire [31:0] cur_base = base_mem[region_number_reg];
   wire [31:0] cur_attr = attr_mem[region_number_reg];
   wire cur_hit;
   wire cur_fetch_ok;
   wire [31:0] cur_mask;
   wire [5:0] cur_log2;

   // Address check of the selected region, visible in the status register
   region_match u_match (
      .base(cur_base),
      .attr(cur_attr),
      .addr(check_addr_reg),
      .fetch(check_fetch_reg),
      .hit(cur_hit),
      .allow_fetch(cur_fetch_ok),
      .base_mask(cur_mask),
      .size_log2(cur_log2)
   );

   // Strobe expansion to a bit mask
   function [31:0] lane_mask;
      input [3:0] strb;
      begin
         lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      end
   endfunction

   wire is_base_off = (awaddr_reg == `OFF_BASE_PRIMARY) || (awaddr_reg == `OFF_BASE_ALIAS_ONE) ||
      (awaddr_reg == `OFF_BASE_ALIAS_TWO) || (awaddr_reg == `OFF_BASE_ALIAS_THREE); // [R19] [R11]
   wire is_attr_off = (awaddr_reg == `OFF_ATTR_PRIMARY) || (awaddr_reg == `OFF_ATTR_ALIAS_ONE) ||
      (awaddr_reg == `OFF_ATTR_ALIAS_TWO) || (awaddr_reg == `OFF_ATTR_ALIAS_THREE); // [R19] [R12]
   wire wr_known = is_base_off || is_attr_off || (awaddr_reg == `OFF_REGION_NUMBER) ||
      (awaddr_reg == `OFF_REGION_CHECK) || (awaddr_reg == `OFF_REGION_STATUS);
   wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire [31:0] wmask = lane_mask(wstrb_reg);

   // Target region of a base write: written index when select-valid is set
   wire sel_valid = wdata_reg[`BASE_VALID_BIT] && wstrb_reg[0];
   wire [IDX_W-1:0] base_target = sel_valid ? wdata_reg[IDX_W-1:0] : region_number_reg; // [R7] [R8]

   // Write channel: address and data taken in either order, response after both
   always @(posedge core_clk) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Region storage and selection updates
   always @(posedge core_clk) begin
      if (!resetn) begin
         region_number_reg <= {IDX_W{1'b0}};
         check_addr_reg <= 32'h00000000;
         check_fetch_reg <= 1'b0;
         for (i = 0; i < REGIONS; i = i + 1) begin
            base_mem[i] <= 32'h00000000;
            attr_mem[i] <= 32'h00000000;
         end
      end else if (do_write) begin
         if (is_base_off) begin
            if (sel_valid)
               region_number_reg <= wdata_reg[IDX_W-1:0]; // [R8] [R18]
            // Only the address bits are stored; valid and index live elsewhere
            base_mem[base_target] <= (base_mem[base_target] & ~wmask) |
               (wdata_reg & wmask & `BASE_STORE_MASK); // [R7] [R8] [R4]
         end
         if (is_attr_off)
            attr_mem[region_number_reg] <= (attr_mem[region_number_reg] & ~(wmask & `ATTR_WRITE_MASK)) |
               (wdata_reg & wmask & `ATTR_WRITE_MASK); // [R13] [R18] [R12]
         if (awaddr_reg == `OFF_REGION_NUMBER && wstrb_reg[0])
            region_number_reg <= wdata_reg[IDX_W-1:0];
         if (awaddr_reg == `OFF_REGION_CHECK) begin
            check_addr_reg <= (check_addr_reg & ~wmask) | (wdata_reg & wmask);
         end
         if (awaddr_reg == `OFF_REGION_STATUS && wstrb_reg[0])
            check_fetch_reg <= wdata_reg[0];
      end
   end

   // Base read: address bits above N, valid reads zero, index is region number
   wire [31:0] base_view = (cur_attr[`ATTR_SIZE_MSB:`ATTR_SIZE_LSB] == `SIZE_FULL_MAP) ?
      {28'h0000000, 1'b0, 3'h0} : (cur_base & cur_mask); // [R3] [R4] [R6]
   wire [31:0] base_rd = base_view | {{(32-IDX_W){1'b0}}, region_number_reg}; // [R9] [R10]

   // Read decode
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `OFF_REGION_NUMBER: rd_val = {{(32-IDX_W){1'b0}}, region_number_reg};
         `OFF_BASE_PRIMARY, `OFF_BASE_ALIAS_ONE,
         `OFF_BASE_ALIAS_TWO, `OFF_BASE_ALIAS_THREE: rd_val = base_rd; // [R19] [R11]
         `OFF_ATTR_PRIMARY, `OFF_ATTR_ALIAS_ONE,
         `OFF_ATTR_ALIAS_TWO, `OFF_ATTR_ALIAS_THREE: rd_val = cur_attr; // [R19] [R12]
         `OFF_REGION_CHECK: rd_val = check_addr_reg;
         `OFF_REGION_STATUS: rd_val = {16'h0000, 2'h0, cur_log2, 5'h00, cur_fetch_ok, cur_hit, check_fetch_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel: one cycle after the address is taken
   always @(posedge core_clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // region_protect_alias_regs

//--- sim/region_protect_properties.sv
`timescale 1ns/10ps
// Register port checker: handshake holding, latency and readback shape
module region_protect_checker (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Write channels
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // Read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   reg [7:0] rd_addr_reg;
   wire base_rd;
   wire attr_rd;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Remember which register the answer in flight belongs to
   always @(posedge core_clk) begin
      if (!resetn) rd_addr_reg <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
   end
   // Base words sit at 04/0c/14/1c, attribute words at 08/10/18/20
   assign base_rd = rd_addr_reg[2:0] == 3'h4 && rd_addr_reg <= 8'h1c;
   assign attr_rd = rd_addr_reg[2:0] == 3'h0 && rd_addr_reg >= 8'h08 && rd_addr_reg <= 8'h20;
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // Both halves are first latched, so the response shows two edges after a joint take
   b_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   valid_zero_a: assert property (s_axi_rvalid && base_rd |-> !s_axi_rdata[4])
      else $error("select bit read back set");
   attr_mask_a: assert property (s_axi_rvalid && attr_rd |-> (s_axi_rdata & ~32'h173fff3f) == 32'h0)
      else $error("reserved attribute bit read set");
   unmapped_a: assert property (s_axi_rvalid && rd_addr_reg > 8'h28 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
      else $error("unmapped read not refused");
   // Main traffic shapes
   cover property (s_axi_rvalid && base_rd);
   cover property (s_axi_rvalid && attr_rd);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // region_protect_checker
bind region_protect_alias_regs region_protect_checker chk (.*);

//--- sim/testbench.sv
`timescale 1ns/10ps
// Drives the register port as a bus master and judges readback
module testbench;
   reg core_clk = 0;
   reg resetn = 0;
   reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   reg [31:0] s_axi_wdata = 0;
   reg [3:0] s_axi_wstrb = 0;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int failures = 0, num_checks = 0;
   region_protect_alias_regs dut (.*);
   always #2 core_clk = ~core_clk;
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Requests held until taken; ready held until the answer arrives
   task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rc(input string nm, input [7:0] a, input [31:0] exp, input [1:0] er, input [31:0] m = 32'hffffffff);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            chk(nm, s_axi_rdata & m, exp);
            chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   task t_select;
      rc("base_reset", 8'h14, 32'h0, 2'h0);
      wr(8'h1c, 32'h00010013, 4'hf, 2'h0);
      wr(8'h18, 32'h1000001f, 4'hf, 2'h0);
      rc("base_sel", 8'h14, 32'h00010003, 2'h0);
      rc("region_num", 8'h00, 32'h3, 2'h0);
      wr(8'h14, 32'h00020005, 4'hf, 2'h0);
      rc("base_keep", 8'h1c, 32'h00020003, 2'h0);
      wr(8'h14, 32'h00040015, 4'hf, 2'h0);
      rc("attr_other", 8'h20, 32'h0, 2'h0);
      wr(8'h1c, 32'h00010013, 4'hf, 2'h0);
      rc("attr_back", 8'h10, 32'h1000001f, 2'h0);
      $display("test select done");
   endtask
   // 64 KB region at 0x00010000; status low bits and size field compared
   task t_fetch;
      wr(8'h24, 32'h00010010, 4'hf, 2'h0);
      wr(8'h28, 32'h1, 4'hf, 2'h0);
      rc("fetch_blocked", 8'h28, 32'h00001003, 2'h0, 32'h3f07);
      wr(8'h18, 32'h0000001f, 4'hf, 2'h0);
      rc("fetch_open", 8'h28, 32'h00001007, 2'h0, 32'h3f07);
      wr(8'h24, 32'h0001fffc, 4'hf, 2'h0);
      rc("hit_top", 8'h28, 32'h2, 2'h0, 32'h2);
      wr(8'h24, 32'h00020000, 4'hf, 2'h0);
      rc("miss_above", 8'h28, 32'h0, 2'h0, 32'h2);
      wr(8'h24, 32'h00010010, 4'hf, 2'h0);
      wr(8'h18, 32'h0000011f, 4'hf, 2'h0);
      rc("sub_off", 8'h28, 32'h0, 2'h0, 32'h2);
      wr(8'h18, 32'h0000001e, 4'hf, 2'h0);
      rc("region_off", 8'h28, 32'h0, 2'h0, 32'h2);
      $display("test fetch done");
   endtask
   task t_size;
      wr(8'h18, 32'h00000009, 4'hf, 2'h0);
      wr(8'h14, 32'h000000e3, 4'hf, 2'h0);
      rc("base_min", 8'h14, 32'h000000e3, 2'h0);
      wr(8'h18, 32'h0000003f, 4'hf, 2'h0);
      rc("base_full", 8'h1c, 32'h00000003, 2'h0);
      rc("log2_full", 8'h28, 32'h00002000, 2'h0, 32'h3f00);
      $display("test size done");
   endtask
   task t_half;
      wr(8'h20, 32'hffffffff, 4'hf, 2'h0);
      rc("attr_mask", 8'h20, 32'h173fff3f, 2'h0);
      wr(8'h20, 32'h07050000, 4'hc, 2'h0);
      rc("attr_upper", 8'h18, 32'h0705ff3f, 2'h0);
      wr(8'h18, 32'h0000001e, 4'h3, 2'h0);
      rc("attr_lower", 8'h20, 32'h0705001e, 2'h0);
      wr(8'h40, 32'hffffffff, 4'hf, 2'h2);
      rc("unmapped", 8'h40, 32'h0, 2'h2);
      $display("test half and unmapped done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Main sequence after six cycles of reset
   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      t_select;
      t_fetch;
      t_size;
      t_half;
      finish_test;
   end
   // Watchdog: the whole run needs under two hundred cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      finish_test;
   end
endmodule // testbench
